// File: shared/bsfs_pkg.sv
// Constants and types shared by the buck start-up and fault sequencer
package bsfs_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int BLANK_TIME_NS = 160;
  localparam int BLANK_CYCLES = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_W = 3;
  localparam logic [BLANK_W-1:0] BLANK_LIMIT = BLANK_W'(BLANK_CYCLES);

  // Switching-cycle counts
  localparam int HICCUP_CYCLES = 4096;
  localparam int PG_DELAY_CYCLES = 256;
  localparam int PG_W = 9;

  // Pre-bias ramp pulse groups
  localparam int RAMP_W = 6;
  localparam logic [RAMP_W-1:0] RAMP_PULSES_0 = 6'h20;
  localparam logic [RAMP_W-1:0] RAMP_PULSES_1 = 6'h10;
  localparam logic [RAMP_W-1:0] RAMP_PULSES_2 = 6'h08;
  localparam logic [1:0] STEP_FULL = 2'h3;

  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_HICCUP = 8'h08;
  localparam logic CTRL_RESET = 1'h0;
  localparam int CTRL_FORCE_OFF_BIT = 0;
  localparam int HICCUP_CNT_W = 16;

  // Sequencer states
  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_SOFTSTART = 6'h02,
    ST_RAMP = 6'h04,
    ST_RUN = 6'h08,
    ST_HICCUP = 6'h10,
    ST_THERMAL = 6'h20
  } bsfs_state_t;

endpackage : bsfs_pkg

// File: rtl/bsfs_ramp.sv
// Low-side pre-bias ramp step counter
`timescale 1ns/1ps
module bsfs_ramp
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic lsPulse,
  // Result
  output logic [1:0] step,
  output logic done
);

  localparam int RAMP_W_L = bsfs_pkg::RAMP_W;
  logic [1:0] step_reg;
  logic [RAMP_W_L-1:0] cnt_reg;
  logic done_reg;

  function automatic logic [RAMP_W_L-1:0] groupLast(input logic [1:0] s);
    case (s)
      2'h0: groupLast = bsfs_pkg::RAMP_PULSES_0 - 6'h01;
      2'h1: groupLast = bsfs_pkg::RAMP_PULSES_1 - 6'h01;
      default: groupLast = bsfs_pkg::RAMP_PULSES_2 - 6'h01;
    endcase
  endfunction : groupLast

  wire advance = lsPulse & ~done_reg;
  wire groupEnd = advance & (cnt_reg == groupLast(step_reg));

  always_ff @(posedge clk_sys)
  begin
    if (rst || clear)
    begin
      step_reg <= 2'h0;
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end
    else if (groupEnd)
    begin
      cnt_reg <= '0;
      step_reg <= 2'(step_reg + 2'h1); // [R2]
      done_reg <= (step_reg == 2'h2); // [R3]
    end
    else if (advance)
    begin
      cnt_reg <= RAMP_W_L'(cnt_reg + 6'h01); // [R3]
    end
  end

  assign step = step_reg;
  assign done = done_reg;

endmodule : bsfs_ramp

// File: rtl/bsfs_sequencer.sv
// Start-up, protection and power-good sequencer with AHB-Lite registers
// Behaviour
// [R1] Low-side stays off until the first high-side gate pulse after start.
// [R2] Low-side on-fraction widens in steps of 25, 50, 75 and 100 percent.
// [R3] Each ramp step lasts a fixed group of 32, 16, then 8 pulses.
// [R4] Soft-start begins only while power-on-ready is high.
// [R5] Over-current is watched during soft-start and ramp as well as running.
// [R6] Enable below shutdown level puts both drivers into high impedance.
// [R7] Soft-start node forced low shuts output; restart needs release and fresh ramp.
// [R8] Over-current trip latches a flag and enters hiccup.
// [R9] Hiccup discharges soft-start for 4096 switching cycles, then clears flag.
// [R10] Hiccup and soft-start repeat while the overload persists.
// [R11] Over-current is ignored until 160 ns after low-side gate rises.
// [R12] Over-temperature turns both switches off and discharges soft-start.
// [R13] Restart follows automatically once over-temperature indication clears.
// [R14] Power-good needs feedback inside the window comparator.
// [R15] Power-good is open drain; board pull-up makes the high level.
// [R16] Power-good also needs soft-start above its 2.1 V level.
// [R17] Power-good releases 256 switching cycles after feedback enters window.
// [R18] Both drivers stay off while supply or enable is below lockout.
// [R19] Power-good pulls low on window exit, fault or lost ready; count restarts.
// [R20] Cycle counters and fault latches reset while power-on-ready is low.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module bsfs_sequencer
#(
  parameter int HICCUP_CYCLES = bsfs_pkg::HICCUP_CYCLES,
  parameter int PG_DELAY_CYCLES = bsfs_pkg::PG_DELAY_CYCLES
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Comparator and oscillator inputs
  input wire logic porReady,
  input wire logic ssForcedLow,
  input wire logic ssAbovePgLevel,
  input wire logic ocTrip,
  input wire logic otTrip,
  input wire logic fbInWindow,
  input wire logic hsGatePulse,
  input wire logic lsGateHigh,
  input wire logic swTick,
  // Driver controls
  output logic hsDriveEn,
  output logic lsDriveEn,
  output logic driversHiZ,
  output logic [1:0] lsRampStep,
  output logic ssDischarge,
  output logic overcurrentLatch,
  // Open-drain power good
  output logic powerGoodOut,
  output logic powerGoodOe,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  localparam int HC_W = $clog2(HICCUP_CYCLES + 1);
  localparam logic [HC_W-1:0] HICCUP_LAST = HC_W'(HICCUP_CYCLES - 1);
  localparam logic [bsfs_pkg::PG_W-1:0] PG_DONE = bsfs_pkg::PG_W'(PG_DELAY_CYCLES);

  // State and counters
  bsfs_pkg::bsfs_state_t state_reg;
  bsfs_pkg::bsfs_state_t stateNext;
  logic [HC_W-1:0] hiccupCnt_reg;
  logic [bsfs_pkg::PG_W-1:0] pgCnt_reg;
  logic [bsfs_pkg::BLANK_W-1:0] blankCnt_reg;
  logic lsGatePrev_reg;
  logic ocLatch_reg;
  logic ocLatchNext;
  logic [bsfs_pkg::HICCUP_CNT_W-1:0] hiccupEvents_reg;

  // Registered outputs
  logic hsDriveEn_reg;
  logic lsDriveEn_reg;
  logic driversHiZ_reg;
  logic [1:0] lsRampStep_reg;
  logic ssDischarge_reg;
  logic powerGood_reg;
  logic powerGoodOe_reg;
  logic powerGoodOut_reg;

  // Bus state
  logic forceOff_reg;
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;

  // Ramp counter
  logic [1:0] rampStep;
  logic rampDone;

  // Decoding
  wire holdCount = rst | ~porReady; // [R20]
  wire inOff = (state_reg == bsfs_pkg::ST_OFF);
  wire inSoft = (state_reg == bsfs_pkg::ST_SOFTSTART);
  wire inRamp = (state_reg == bsfs_pkg::ST_RAMP);
  wire inRun = (state_reg == bsfs_pkg::ST_RUN);
  wire inHiccup = (state_reg == bsfs_pkg::ST_HICCUP);
  wire inThermal = (state_reg == bsfs_pkg::ST_THERMAL);
  wire switching = inSoft | inRamp | inRun;
  wire ssExternalLow = ssForcedLow & ~ssDischarge_reg; // [R7]
  wire shutDown = ~porReady | forceOff_reg | ssExternalLow; // [R4] [R7] [R18]
  wire lsRise = lsGateHigh & ~lsGatePrev_reg;
  wire ocSampleOk = lsGateHigh & (blankCnt_reg == bsfs_pkg::BLANK_LIMIT); // [R11]
  wire ocSet = switching & ocSampleOk & ocTrip & ~shutDown & ~otTrip; // [R5] [R8]
  wire hiccupDone = inHiccup & swTick & (hiccupCnt_reg == HICCUP_LAST); // [R9]
  wire pgQualify = fbInWindow & ssAbovePgLevel & (inRamp | inRun) & ~ocLatch_reg; // [R14] [R16]
  wire pgReached = (pgCnt_reg == PG_DONE);
  wire powerGoodNext = pgQualify & pgReached & porReady; // [R17] [R19]
  wire rampClear = holdCount | ~inRamp;
  wire lsPulseCount = inRamp & lsRise;

  // Bus decoding
  wire addrPhase = hsel & htrans[1] & hready;
  wire [7:0] busAddr = haddr[7:0];
  wire [31:0] statusWord = {16'h0000, 2'h0, state_reg, powerGood_reg, ocLatch_reg,
                            porReady, otTrip, rampDone, lsRampStep_reg, forceOff_reg};

  function automatic logic [31:0] readMux(input logic [7:0] a, input logic [31:0] st,
                                          input logic fo,
                                          input logic [bsfs_pkg::HICCUP_CNT_W-1:0] hc);
    case (a)
      bsfs_pkg::ADDR_CTRL: readMux = {31'h00000000, fo};
      bsfs_pkg::ADDR_STATUS: readMux = st;
      bsfs_pkg::ADDR_HICCUP: readMux = {16'h0000, hc};
      default: readMux = 32'h00000000;
    endcase
  endfunction : readMux

  // Next state
  always_comb
  begin
    stateNext = state_reg;
    if (shutDown)
    begin
      stateNext = bsfs_pkg::ST_OFF; // [R6] [R18]
    end
    else if (otTrip)
    begin
      stateNext = bsfs_pkg::ST_THERMAL; // [R12]
    end
    else
    begin
      case (state_reg)
        bsfs_pkg::ST_OFF: stateNext = bsfs_pkg::ST_SOFTSTART; // [R4] [R7]
        bsfs_pkg::ST_SOFTSTART:
        begin
          if (ocSet)
            stateNext = bsfs_pkg::ST_HICCUP; // [R8]
          else if (hsGatePulse)
            stateNext = bsfs_pkg::ST_RAMP; // [R1]
        end
        bsfs_pkg::ST_RAMP:
        begin
          if (ocSet)
            stateNext = bsfs_pkg::ST_HICCUP; // [R5]
          else if (rampDone)
            stateNext = bsfs_pkg::ST_RUN; // [R2]
        end
        bsfs_pkg::ST_RUN:
        begin
          if (ocSet)
            stateNext = bsfs_pkg::ST_HICCUP; // [R8]
        end
        bsfs_pkg::ST_HICCUP:
        begin
          if (hiccupDone)
            stateNext = bsfs_pkg::ST_SOFTSTART; // [R10]
        end
        bsfs_pkg::ST_THERMAL: stateNext = bsfs_pkg::ST_SOFTSTART; // [R13]
        default: stateNext = bsfs_pkg::ST_OFF;
      endcase
    end
  end

  // Set wins over the clear at hiccup end
  assign ocLatchNext = ocSet | (ocLatch_reg & ~hiccupDone); // [R8] [R9]

  // Sequencer state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state_reg <= bsfs_pkg::ST_OFF;
    else
      state_reg <= stateNext;
  end

  // Fault latch and hiccup event count
  always_ff @(posedge clk_sys)
  begin
    if (holdCount)
    begin
      ocLatch_reg <= 1'b0; // [R20]
      hiccupEvents_reg <= '0;
    end
    else
    begin
      ocLatch_reg <= ocLatchNext;
      if (ocSet && !ocLatch_reg)
        hiccupEvents_reg <= bsfs_pkg::HICCUP_CNT_W'(hiccupEvents_reg + 16'h0001); // [R10]
    end
  end

  // Hiccup switching-cycle counter
  always_ff @(posedge clk_sys)
  begin
    if (holdCount || !inHiccup)
      hiccupCnt_reg <= '0;
    else if (swTick)
      hiccupCnt_reg <= HC_W'(hiccupCnt_reg + 1'b1); // [R9]
  end

  // Over-current blanking after low-side gate rise
  always_ff @(posedge clk_sys)
  begin
    if (holdCount)
    begin
      blankCnt_reg <= '0;
      lsGatePrev_reg <= 1'b0;
    end
    else
    begin
      lsGatePrev_reg <= lsGateHigh;
      if (!lsGateHigh)
        blankCnt_reg <= '0; // [R11]
      else if (blankCnt_reg != bsfs_pkg::BLANK_LIMIT)
        blankCnt_reg <= bsfs_pkg::BLANK_W'(blankCnt_reg + 3'h1); // [R11]
    end
  end

  // Power-good qualification counter
  always_ff @(posedge clk_sys)
  begin
    if (holdCount || !pgQualify)
      pgCnt_reg <= '0; // [R19]
    else if (swTick && !pgReached)
      pgCnt_reg <= bsfs_pkg::PG_W'(pgCnt_reg + 9'h001); // [R17]
  end

  // Registered driver and power-good outputs
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      hsDriveEn_reg <= 1'b0;
      lsDriveEn_reg <= 1'b0;
      driversHiZ_reg <= 1'b1;
      lsRampStep_reg <= 2'h0;
      ssDischarge_reg <= 1'b0;
      powerGood_reg <= 1'b0;
      powerGoodOe_reg <= 1'b1;
      powerGoodOut_reg <= 1'b0;
    end
    else
    begin
      hsDriveEn_reg <= (stateNext == bsfs_pkg::ST_SOFTSTART) | (stateNext == bsfs_pkg::ST_RAMP)
                       | (stateNext == bsfs_pkg::ST_RUN); // [R12] [R18]
      lsDriveEn_reg <= (stateNext == bsfs_pkg::ST_RAMP) | (stateNext == bsfs_pkg::ST_RUN); // [R1]
      driversHiZ_reg <= ~porReady; // [R6]
      lsRampStep_reg <= inRun ? bsfs_pkg::STEP_FULL : rampStep; // [R2]
      ssDischarge_reg <= (stateNext == bsfs_pkg::ST_HICCUP)
                         | (stateNext == bsfs_pkg::ST_THERMAL); // [R9] [R12]
      powerGood_reg <= powerGoodNext;
      powerGoodOe_reg <= ~powerGoodNext; // [R15] [R19]
      powerGoodOut_reg <= 1'b0; // [R15]
    end
  end

  // Bus write path and control register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      forceOff_reg <= bsfs_pkg::CTRL_RESET;
    end
    else
    begin
      wrPend_reg <= addrPhase & hwrite;
      if (addrPhase)
        wrAddr_reg <= busAddr;
      if (wrPend_reg && wrAddr_reg == bsfs_pkg::ADDR_CTRL)
        forceOff_reg <= hwdata[bsfs_pkg::CTRL_FORCE_OFF_BIT];
    end
  end

  // Bus read path and response
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
    else
    begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      if (addrPhase && !hwrite)
        hrdata_reg <= readMux(busAddr, statusWord, forceOff_reg, hiccupEvents_reg);
    end
  end

  bsfs_ramp u_ramp
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(rampClear),
    .lsPulse(lsPulseCount),
    .step(rampStep),
    .done(rampDone)
  );

  assign hsDriveEn = hsDriveEn_reg;
  assign lsDriveEn = lsDriveEn_reg;
  assign driversHiZ = driversHiZ_reg;
  assign lsRampStep = lsRampStep_reg;
  assign ssDischarge = ssDischarge_reg;
  assign overcurrentLatch = ocLatch_reg;
  assign powerGoodOut = powerGoodOut_reg;
  assign powerGoodOe = powerGoodOe_reg;
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;

endmodule : bsfs_sequencer

// File: tb/bsfs_board.sv
// Board model: power-good pull-up and soft-start pull-down
`timescale 1ns/1ps
module bsfs_board
(
  // Power good pin
  input wire logic powerGoodOut,
  input wire logic powerGoodOe,
  output logic pgWire,
  // Soft-start node
  input wire logic ssPullReq,
  output logic ssForcedLow
);
  assign pgWire = powerGoodOe ? powerGoodOut : 1'h1;
  assign ssForcedLow = ssPullReq;
endmodule : bsfs_board

// File: tb/bsfs_chk.sv
// Port checker for the sequencer
`timescale 1ns/1ps
module bsfs_chk
#(
  parameter int HICCUP_CYCLES = 8,
  parameter int PG_DELAY_CYCLES = 4
)
(
  // Inputs
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic porReady,
  input wire logic ssAbovePgLevel,
  input wire logic ocTrip,
  input wire logic otTrip,
  input wire logic fbInWindow,
  input wire logic hsGatePulse,
  input wire logic lsGateHigh,
  input wire logic swTick,
  // Outputs
  input wire logic hsDriveEn,
  input wire logic lsDriveEn,
  input wire logic driversHiZ,
  input wire logic [1:0] lsRampStep,
  input wire logic ssDischarge,
  input wire logic overcurrentLatch,
  input wire logic powerGoodOut,
  input wire logic powerGoodOe
);
  logic [31:0] hcCnt;
  logic [31:0] pgCnt;
  wire pgQual = porReady && fbInWindow && ssAbovePgLevel && lsDriveEn && !overcurrentLatch;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  always_ff @(posedge clk_sys)
  begin
    hcCnt <= (rst || !overcurrentLatch) ? 32'h0 : hcCnt + {31'h0, swTick};
    pgCnt <= (rst || !pgQual) ? 32'h0 : pgCnt + {31'h0, swTick};
  end
  a_drv_lockout: assert property (!porReady |=> driversHiZ && !hsDriveEn && !lsDriveEn)
    else $error("drivers on without ready");
  a_por_start: assert property ($rose(hsDriveEn) |-> $past(porReady))
    else $error("start without ready");
  a_ls_after_hs: assert property ($rose(lsDriveEn) |-> $past(hsGatePulse))
    else $error("low side before high pulse");
  a_ramp_inc: assert property (lsDriveEn && $past(lsDriveEn) && $changed(lsRampStep)
    |-> lsRampStep == $past(lsRampStep) + 2'h1) else $error("ramp step skipped");
  a_oc_blank: assert property ($rose(overcurrentLatch)
    |-> $past(ocTrip) && $past(lsGateHigh) && $past(lsGateHigh, 3)) else $error("no blanking");
  a_oc_hiccup: assert property ($rose(overcurrentLatch) |-> ssDischarge && !hsDriveEn)
    else $error("trip without hiccup");
  a_hiccup_len: assert property ($fell(overcurrentLatch) && $past(porReady) && !$past(rst)
    |-> hcCnt == HICCUP_CYCLES) else $error("hiccup length wrong");
  a_pg_release: assert property ($fell(powerGoodOe) |-> $past(fbInWindow)
    && $past(ssAbovePgLevel) && pgCnt >= PG_DELAY_CYCLES) else $error("early power good");
  a_pg_drop: assert property (!porReady || !fbInWindow || overcurrentLatch |=> powerGoodOe)
    else $error("power good kept");
  a_pg_od: assert property (powerGoodOe |-> !powerGoodOut)
    else $error("power good driven high");
  a_ot_off: assert property (otTrip |=> !hsDriveEn && !lsDriveEn)
    else $error("switches on in thermal");
  cover property ($rose(overcurrentLatch));
  cover property ($fell(powerGoodOe));
  cover property (lsDriveEn && lsRampStep == 2'h3);
endmodule : bsfs_chk
bind bsfs_sequencer bsfs_chk #(.HICCUP_CYCLES(HICCUP_CYCLES), .PG_DELAY_CYCLES(PG_DELAY_CYCLES))
  u_chk (.clk_sys, .rst, .porReady, .ssAbovePgLevel, .ocTrip, .otTrip, .fbInWindow,
  .hsGatePulse, .lsGateHigh, .swTick, .hsDriveEn, .lsDriveEn, .driversHiZ, .lsRampStep,
  .ssDischarge, .overcurrentLatch, .powerGoodOut, .powerGoodOe);

// File: tb/buck_startup_fault_sequencer_bench.sv
// Self-checking bench for the sequencer
`timescale 1ns/1ps
module buck_startup_fault_sequencer_bench;
  localparam int HC = 8;
  localparam int PD = 4;
  logic clk_sys, rst, porReady, ssAbovePgLevel, ocTrip, otTrip, fbInWindow, hsGatePulse;
  logic lsGateHigh, swTick, ssPullReq, ssForcedLow, pgWire, hsDriveEn, lsDriveEn, driversHiZ;
  logic ssDischarge, overcurrentLatch, powerGoodOut, powerGoodOe, hsel, hwrite, hreadyout, hresp;
  logic [1:0] lsRampStep, htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int miscompares, checks, cycles, tc, s, n, trips;
  int grp[3] = '{32, 16, 8};
  bsfs_sequencer #(.HICCUP_CYCLES(HC), .PG_DELAY_CYCLES(PD)) DUT (.clk_sys, .rst, .porReady,
    .ssForcedLow, .ssAbovePgLevel, .ocTrip, .otTrip, .fbInWindow, .hsGatePulse, .lsGateHigh,
    .swTick, .hsDriveEn, .lsDriveEn, .driversHiZ, .lsRampStep, .ssDischarge, .overcurrentLatch,
    .powerGoodOut, .powerGoodOe, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp);
  bsfs_board board (.powerGoodOut, .powerGoodOe, .pgWire, .ssPullReq, .ssForcedLow);
  initial
  begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    tc <= (tc == 3) ? 0 : tc + 1;
    swTick <= (tc == 3);
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end
  task end_sim();
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc
  task ticks(input int k);
    repeat (k)
    begin
      @(posedge clk_sys);
      while (swTick !== 1'h1)
        @(posedge clk_sys);
    end
  endtask : ticks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    cyc(1);
    while (hreadyout !== 1'h1)
      cyc(1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    cyc(1);
    while (hreadyout !== 1'h1)
      cyc(1);
    rd = hrdata;
    chk(hresp, 32'h0);
  endtask : bus
  task pulse(input int h);
    lsGateHigh <= 1'h1;
    cyc(h);
    lsGateHigh <= 1'h0;
    cyc(2 + $urandom % 3);
  endtask : pulse
  task hsPulse();
    hsGatePulse <= 1'h1;
    cyc(1);
    hsGatePulse <= 1'h0;
    cyc(2);
  endtask : hsPulse
  initial
  begin
    void'($urandom(32'h87c71568));
    {rst, porReady, ssAbovePgLevel, ocTrip, otTrip, fbInWindow, hsGatePulse} = 7'h40;
    {lsGateHigh, ssPullReq, hsel, hwrite, htrans, tc, cycles} = 0;
    {haddr, hwdata, miscompares, checks} = 0;
    cyc(16);
    rst <= 1'h0;
    cyc(1);
    chk(driversHiZ, 1);
    chk(pgWire, 0);
    bus(0, 32'h4, 0);
    chk(rd[13:5], 9'h008);
    bus(1, 32'h10, $urandom);
    bus(0, 32'hc, 0);
    chk(rd, 0);
    bus(1, 32'h0, 1);
    porReady <= 1'h1;
    ssAbovePgLevel <= 1'h1;
    cyc(4);
    chk(hsDriveEn, 0);
    bus(1, 32'h0, 0);
    cyc(3);
    chk({hsDriveEn, lsDriveEn}, 2);
    pulse(2);
    chk(lsDriveEn, 0);
    hsPulse();
    chk({lsDriveEn, lsRampStep}, 4);
    s = 0;
    n = 0;
    for (int i = 0; i < 56; i++)
    begin
      pulse(2);
      n = (n + 1) % grp[s];
      if (n == 0)
        s++;
      chk(lsRampStep, s);
    end
    fbInWindow <= 1'h1;
    ticks(PD - 2);
    cyc(2);
    chk(powerGoodOe, 1);
    ticks(4);
    cyc(2);
    chk({powerGoodOe, pgWire}, 1);
    fbInWindow <= 1'h0;
    cyc(3);
    chk({powerGoodOe, pgWire}, 2);
    fbInWindow <= 1'h1;
    ssAbovePgLevel <= 1'h0;
    ticks(PD + 2);
    cyc(2);
    chk(powerGoodOe, 1);
    ssAbovePgLevel <= 1'h1;
    ticks(PD - 2);
    cyc(2);
    chk(powerGoodOe, 1);
    ticks(4);
    cyc(2);
    chk(powerGoodOe, 0);
    ocTrip <= 1'h1;
    repeat (3) pulse(2);
    chk(overcurrentLatch, 0);
    lsGateHigh <= 1'h1;
    cyc(8);
    chk({overcurrentLatch, ssDischarge, hsDriveEn, powerGoodOe}, 13);
    trips = 1;
    ticks(HC - 2);
    chk(overcurrentLatch, 1);
    for (int i = 0; i < 40 && overcurrentLatch === 1'h1; i++)
      cyc(1);
    chk(overcurrentLatch, 0);
    cyc(8);
    chk(overcurrentLatch, 1);
    trips++;
    ocTrip <= 1'h0;
    lsGateHigh <= 1'h0;
    ticks(HC + 2);
    cyc(2);
    chk({overcurrentLatch, hsDriveEn}, 1);
    bus(0, 32'h8, 0);
    chk(rd[15:0], trips);
    otTrip <= 1'h1;
    cyc(3);
    chk({hsDriveEn, ssDischarge}, 1);
    otTrip <= 1'h0;
    cyc(3);
    chk({hsDriveEn, lsDriveEn}, 2);
    ssPullReq <= 1'h1;
    cyc(3);
    chk(hsDriveEn, 0);
    ssPullReq <= 1'h0;
    cyc(3);
    chk({hsDriveEn, lsDriveEn}, 2);
    hsPulse();
    porReady <= 1'h0;
    cyc(3);
    chk({driversHiZ, hsDriveEn, lsDriveEn, powerGoodOe}, 9);
    bus(0, 32'h8, 0);
    chk(rd[15:0], 0);
    end_sim();
  end
endmodule : buck_startup_fault_sequencer_bench
